// File: shared/crx_pkg.sv
// crx_pkg: constants and types shared by the receive/control block
// assumes a single core_clk domain at 20 MHz
package crx_pkg;
	// register indices on the documented control port
	localparam logic [3:0] REG_POWER_MODE   = 4'h0;
	localparam logic [3:0] REG_TX_GAIN_SIDE = 4'h1;
	localparam logic [3:0] REG_RX_ANALOG    = 4'h2;
	localparam logic [3:0] REG_RX_GAIN      = 4'h3;
	localparam logic [3:0] REG_DECODED      = 4'ha;
	// field positions
	localparam int RXA_FILT_BYP = 4;
	localparam int RXA_MAIN_PD  = 5;
	localparam int RXA_AUX_PD   = 6;
	localparam int PM_LOOPBACK  = 5;
	localparam int PM_BCLK_SEQ  = 7;
	localparam int PM_ANA_PD    = 0;
	localparam int PM_DIG_PD    = 1;
	localparam int PM_MODE_LO   = 3;
	// reset values
	localparam logic [7:0] RST_POWER_MODE   = 8'h00;
	localparam logic [7:0] RST_TX_GAIN_SIDE = 8'h00;
	localparam logic [7:0] RST_RX_ANALOG    = 8'h00;
	localparam logic [7:0] RST_RX_GAIN      = 8'h80;
	// interface mode value selecting plain companded codec
	localparam logic [1:0] MODE_PCM_CODEC   = 2'h1;
	// enable lengths and frame counts
	localparam logic [3:0] LEN_16K = 4'h2;
	localparam logic [3:0] LEN_24K = 4'h3;
	localparam logic [3:0] LEN_32K = 4'h4;
	localparam logic [3:0] LEN_64K = 4'h8;
	localparam logic [1:0] TX_QUIET_FRAMES = 2'h2;
	// timing: core clock and sequencing clock
	localparam int CORE_HZ   = 20000000;
	localparam int SEQ_HZ    = 256000;
	localparam int SEQ_HALF  = CORE_HZ / (2 * SEQ_HZ);
	// decode rate selection
	typedef enum logic [2:0] {CRX_R16, CRX_R24, CRX_R32, CRX_R64, CRX_RBAD} crx_rate_e;
endpackage

// File: hw/crx_core.sv
// crx_core: receive word capture, rate decode, control registers, power sequencing
// assumes pins asynchronous to core_clk; control port is a simple indexed write/read port
//
// Overview of operation
// - receive words on serial in, far clocks
// - rate chosen from enable length in clocks
// - rate applied per frame to that word
// - decode request held after complete word until taken
// - one decode per frame in duplex
// - sync adjust skipped when digital gain used
// - gain multiplies 13-bit linear sample
// - last decoded word readable by software
// - bit removes receive smoothing filter
// - three-bit trim attenuation zero to seven
// - main driver down by bit or pin
// - aux driver down by its bit
// - three-bit sidetone gain select
// - tone active disables decoder, feeds gain
// - tone blocked at 64k unless loopback
// - reset pin or register powers down
// - powered down keeps outputs high impedance
// - coding state reset on pin rising
// - transmit quiet two frame syncs after power-up
// - prescaler makes 256 kHz sequencing clock
// - receive bit clock as sequencing clock
// - count falling edges, latch data, transfer
// - codec mode transfers full eight bits
`timescale 1ns/1ps
`default_nettype none
module crx_core #(
	parameter int GAIN_W = 8
) (
	// clock and reset
	input  wire logic              core_clk,
	input  wire logic              rst_n,
	// pcm highway pins
	input  wire logic              receive_serial_in,
	input  wire logic              receive_bit_clock,
	input  wire logic              receive_frame_enable,
	input  wire logic              transmit_frame_enable,
	input  wire logic              powerdown_reset_pin,
	input  wire logic              main_driver_inverting_input,
	// control port
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	input  wire logic [3:0]        reg_addr,
	input  wire logic [7:0]        reg_wdata,
	output logic [7:0]             reg_rdata,
	// decoder side (signal processor)
	input  wire logic [12:0]       linear_sample,
	input  wire logic              linear_valid,
	input  wire logic [7:0]        decoded_word,
	input  wire logic              decoded_valid,
	input  wire logic              tone_request,
	output logic                   word_valid,
	input  wire logic              word_ready,
	output logic [7:0]             word_data,
	output logic [2:0]             word_rate,
	output logic                   sync_adjust_en,
	output logic [12:0]            gained_sample,
	output logic                   tone_active,
	output logic                   decoder_enable,
	output logic                   coder_state_reset,
	// analog controls
	output logic                   filter_bypass,
	output logic [2:0]             rx_trim,
	output logic [2:0]             sidetone_sel,
	output logic                   main_driver_pd,
	output logic                   aux_driver_pd,
	output logic                   analog_pd,
	output logic                   seq_clk,
	output logic                   seq_from_bclk,
	output logic                   tx_out_oe_n,
	output logic                   ctrl_out_oe_n
);
	// full state of the block in one record
	typedef struct packed {
		logic [2:0]  bc_s;      // bit clock synchroniser
		logic [2:0]  fs_s;      // frame enable synchroniser
		logic [2:0]  dr_s;      // data synchroniser
		logic [2:0]  ft_s;      // tx frame synchroniser
		logic [2:0]  pd_s;      // reset pin synchroniser
		logic [2:0]  pi_s;      // inverting input synchroniser
		logic        bc_q;      // filtered levels
		logic        fs_q;
		logic        ft_q;
		logic        pd_q;
		logic        pi_q;
		logic [3:0]  cnt;       // falling edges in frame
		logic [7:0]  shf;       // shift register
		logic        b0_v;      // two-entry buffer
		logic [7:0]  b0_d;
		logic [2:0]  b0_r;
		logic        b1_v;
		logic [7:0]  b1_d;
		logic [2:0]  b1_r;
		logic [7:0]  pm;        // registers
		logic [7:0]  tg;
		logic [7:0]  ra;
		logic [7:0]  rg;
		logic [7:0]  dec;
		logic [7:0]  rdat;
		logic [12:0] gsmp;
		logic        crst;
		logic [1:0]  quiet;
		logic [7:0]  div;
		logic        seq;
		logic        last64;    // last closed frame ran at 64k
		logic        tone;      // registered tone enable
		// registered copies of the derived outputs, so every pin leaves a flop
		logic        o_anapd;   // analog section down
		logic        o_sadj;    // sync adjustment allowed
		logic        o_mpd;     // main driver down
		logic        o_apd;     // aux driver down
		logic        o_den;     // decoder enabled
		logic        o_toe_n;   // transmit output enable, low drives
		logic        o_coe_n;   // control port output enable, low drives
	} crx_state_s;

	crx_state_s s_q;  // registered state
	crx_state_s s_d;  // next state
	// rate from a length of the just-closed frame
	function automatic logic [2:0] len_rate(input logic [3:0] len);
		case (len)
			crx_pkg::LEN_16K: len_rate = 3'(crx_pkg::CRX_R16);
			crx_pkg::LEN_24K: len_rate = 3'(crx_pkg::CRX_R24);
			crx_pkg::LEN_32K: len_rate = 3'(crx_pkg::CRX_R32);
			crx_pkg::LEN_64K: len_rate = 3'(crx_pkg::CRX_R64);
			default:          len_rate = 3'(crx_pkg::CRX_RBAD);
		endcase
	endfunction

	logic        bc_fall;   // filtered bit clock falling
	logic        fs_fall;   // frame enable end
	logic        ft_rise;   // tx frame start
	logic        dig_pd;    // digital section down
	logic        pcm_mode;  // codec mode
	logic        push;      // word into buffer
	logic [3:0]  flen;      // length used for rate
	logic [2:0]  frate;     // rate of closing word
	logic        tone_ok;   // tone allowed
	logic [20:0] prod;      // gain product

	// next-state logic
	always_comb begin
		s_d = s_q;
		// three-flop sync, level taken when stages 2 and 3 agree
		s_d.bc_s = {s_q.bc_s[1:0], receive_bit_clock};
		s_d.fs_s = {s_q.fs_s[1:0], receive_frame_enable};
		s_d.dr_s = {s_q.dr_s[1:0], receive_serial_in};
		s_d.ft_s = {s_q.ft_s[1:0], transmit_frame_enable};
		s_d.pd_s = {s_q.pd_s[1:0], powerdown_reset_pin};
		s_d.pi_s = {s_q.pi_s[1:0], main_driver_inverting_input};
		if (s_q.bc_s[1] == s_q.bc_s[2]) s_d.bc_q = s_q.bc_s[2];
		if (s_q.fs_s[1] == s_q.fs_s[2]) s_d.fs_q = s_q.fs_s[2];
		if (s_q.ft_s[1] == s_q.ft_s[2]) s_d.ft_q = s_q.ft_s[2];
		if (s_q.pd_s[1] == s_q.pd_s[2]) s_d.pd_q = s_q.pd_s[2];
		if (s_q.pi_s[1] == s_q.pi_s[2]) s_d.pi_q = s_q.pi_s[2];
		bc_fall = s_q.bc_q && !s_d.bc_q;
		fs_fall = s_q.fs_q && !s_d.fs_q;
		ft_rise = !s_q.ft_q && s_d.ft_q;
		dig_pd = !s_q.pd_q || s_q.pm[crx_pkg::PM_DIG_PD];
		pcm_mode = s_q.pm[crx_pkg::PM_MODE_LO +: 2] == crx_pkg::MODE_PCM_CODEC;
		// count and latch on falling bit clock while frame high
		if (s_q.fs_q && bc_fall && s_q.cnt != 4'hf) begin
			s_d.cnt = s_q.cnt + 4'h1;
			s_d.shf = {s_q.shf[6:0], s_q.dr_s[2]};
		end
		flen = pcm_mode ? crx_pkg::LEN_64K : s_q.cnt;
		frate = len_rate(flen);
		push = fs_fall && !dig_pd && frate != 3'(crx_pkg::CRX_RBAD);
		if (fs_fall) s_d.cnt = 4'h0;
		// two-entry buffer: pop head, then push to first free
		if (s_q.b0_v && word_ready) begin
			s_d.b0_v = s_q.b1_v;
			s_d.b0_d = s_q.b1_d;
			s_d.b0_r = s_q.b1_r;
			s_d.b1_v = 1'b0;
		end
		if (push) begin
			if (!s_d.b0_v) begin
				s_d.b0_v = 1'b1;
				s_d.b0_d = s_q.shf;
				s_d.b0_r = frate;
			end else if (!s_d.b1_v) begin
				s_d.b1_v = 1'b1;
				s_d.b1_d = s_q.shf;
				s_d.b1_r = frate;
			end
			// both full: the word is dropped, decoder stalled too long
		end
		// software writes
		if (reg_wr) begin
			case (reg_addr)
				crx_pkg::REG_POWER_MODE:   s_d.pm = reg_wdata;
				crx_pkg::REG_TX_GAIN_SIDE: s_d.tg = reg_wdata;
				crx_pkg::REG_RX_ANALOG:    s_d.ra = reg_wdata;
				crx_pkg::REG_RX_GAIN:      s_d.rg = reg_wdata;
				default:                   s_d.rg = s_d.rg;
			endcase
		end
		if (decoded_valid) s_d.dec = decoded_word;
		// read mux, unmapped reads zero
		case (reg_addr)
			crx_pkg::REG_POWER_MODE:   s_d.rdat = s_q.pm;
			crx_pkg::REG_TX_GAIN_SIDE: s_d.rdat = s_q.tg;
			crx_pkg::REG_RX_ANALOG:    s_d.rdat = s_q.ra;
			crx_pkg::REG_RX_GAIN:      s_d.rdat = s_q.rg;
			crx_pkg::REG_DECODED:      s_d.rdat = s_q.dec;
			default:                   s_d.rdat = 8'h00;
		endcase
		if (!reg_rd) s_d.rdat = s_q.rdat;
		// linear gain, unity at 0x80
		prod = 21'(signed'(linear_sample) * signed'({1'b0, s_q.rg}));
		if (linear_valid) s_d.gsmp = prod[19:7];
		// coding reset on pin rising
		s_d.crst = !s_q.pd_q && s_d.pd_q;
		// tx stays quiet for two frame syncs after power-up
		if (dig_pd) s_d.quiet = 2'h0;
		else if (ft_rise && s_q.quiet != crx_pkg::TX_QUIET_FRAMES) s_d.quiet = s_q.quiet + 2'h1;
		// prescaler from core clock; frame-locked by restarting on frame start
		if (ft_rise || s_q.div == 8'(crx_pkg::SEQ_HALF - 1)) begin
			s_d.div = 8'h00;
			s_d.seq = ft_rise ? 1'b1 : !s_q.seq;
		end else begin
			s_d.div = s_q.div + 8'h01;
		end
		if (s_q.pm[crx_pkg::PM_BCLK_SEQ]) s_d.seq = s_q.bc_q;
		// remember the rate of the last frame; the live count is zero between frames
		if (fs_fall) s_d.last64 = flen == crx_pkg::LEN_64K;
		// tone generator blocked at 64k unless loopback is on
		tone_ok = tone_request && (!s_q.last64 || s_q.pm[crx_pkg::PM_LOOPBACK]);
		s_d.tone = tone_ok;
		// derived outputs computed from the next state, so they show no extra lag
		// analog section down by pin or by register
		s_d.o_anapd = !s_d.pd_q || s_d.pm[crx_pkg::PM_ANA_PD];
		// sync adjustment only at unity digital gain
		s_d.o_sadj = s_d.rg == crx_pkg::RST_RX_GAIN;
		// main driver down by its bit, its pin or the analog section
		s_d.o_mpd = s_d.ra[crx_pkg::RXA_MAIN_PD] || s_d.pi_q || s_d.o_anapd;
		// aux driver down by its own bit or the analog section
		s_d.o_apd = s_d.ra[crx_pkg::RXA_AUX_PD] || s_d.o_anapd;
		// decoder idle while the tone runs or the digital side sleeps
		s_d.o_den = !tone_ok && s_d.pd_q && !s_d.pm[crx_pkg::PM_DIG_PD];
		// transmit output stays released until the quiet count is full
		s_d.o_toe_n = s_d.quiet != crx_pkg::TX_QUIET_FRAMES;
		// control port output released while powered down
		s_d.o_coe_n = !s_d.pd_q || s_d.pm[crx_pkg::PM_DIG_PD];
	end

	// register the whole state
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			s_q      <= '0;
			s_q.pm   <= crx_pkg::RST_POWER_MODE;
			s_q.tg   <= crx_pkg::RST_TX_GAIN_SIDE;
			s_q.ra   <= crx_pkg::RST_RX_ANALOG;
			s_q.rg   <= crx_pkg::RST_RX_GAIN;
			// outputs start in their safe, powered-down levels
			s_q.o_anapd <= 1'b1;
			s_q.o_sadj  <= 1'b1;
			s_q.o_mpd   <= 1'b1;
			s_q.o_apd   <= 1'b1;
			s_q.o_toe_n <= 1'b1;
			s_q.o_coe_n <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// outputs straight from state flops, no logic after the register
	assign tone_active       = s_q.tone;
	assign word_valid        = s_q.b0_v;
	assign word_data         = s_q.b0_d;
	assign word_rate         = s_q.b0_r;
	assign sync_adjust_en    = s_q.o_sadj;
	assign gained_sample     = s_q.gsmp;
	assign decoder_enable    = s_q.o_den;
	assign coder_state_reset = s_q.crst;
	assign reg_rdata         = s_q.rdat;
	assign filter_bypass     = s_q.ra[crx_pkg::RXA_FILT_BYP];
	assign rx_trim           = s_q.ra[2:0];
	assign sidetone_sel      = s_q.tg[6:4];
	assign main_driver_pd    = s_q.o_mpd;
	assign aux_driver_pd     = s_q.o_apd;
	assign analog_pd         = s_q.o_anapd;
	assign seq_clk           = s_q.seq;
	assign seq_from_bclk     = s_q.pm[crx_pkg::PM_BCLK_SEQ];
	assign tx_out_oe_n       = s_q.o_toe_n;
	assign ctrl_out_oe_n     = s_q.o_coe_n;

	// checks
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	buf_bound_a: assert property (!(s_q.b1_v && !s_q.b0_v)) else $error("buffer hole");
	push_vis_a: assert property (push && !s_q.b0_v |=> word_valid) else $error("word lost");
	bad_len_a: assert property (fs_fall && !pcm_mode && s_q.cnt == 4'h5 |=> !s_q.b1_v || $stable(s_q.b1_v))
		else $error("bad length pushed");
	rate_64_a: assert property (push && !s_q.b0_v && pcm_mode |=> word_rate == 3'(crx_pkg::CRX_R64))
		else $error("codec mode rate");
	quiet_a: assert property (dig_pd |=> ##1 tx_out_oe_n) else $error("tx not quiet");
	crst_a: assert property ($rose(s_q.pd_q) |-> s_q.crst) else $error("no coder reset");
	aux_pd_a: assert property (s_q.ra[crx_pkg::RXA_AUX_PD] |-> aux_driver_pd) else $error("aux up");
	main_pd_a: assert property (s_q.pi_q |-> main_driver_pd) else $error("main up");
	tone_dec_a: assert property (s_q.tone |-> !decoder_enable) else $error("decoder on");
	// register fields land on the pins one cycle after the write
	trim_sel_a: assert property (reg_wr && reg_addr == crx_pkg::REG_RX_ANALOG |=> rx_trim == $past(reg_wdata[2:0]))
		else $error("trim field");
	side_sel_a: assert property (reg_wr && reg_addr == crx_pkg::REG_TX_GAIN_SIDE |=> sidetone_sel == $past(reg_wdata[6:4]))
		else $error("sidetone field");
	// decoded word held for software after each strobe
	dec_hold_a: assert property (decoded_valid |=> s_q.dec == $past(decoded_word)) else $error("readback");
	// pin low: analog down and control output released now, transmit output one cycle later
	ana_down_a: assert property (!s_q.pd_q |-> analog_pd) else $error("analog up");
	out_hiz_a: assert property (!s_q.pd_q |-> ctrl_out_oe_n ##1 tx_out_oe_n) else $error("output driven");
	// tone refused after a 64k frame without loopback
	tone_block_a: assert property (s_q.last64 && !s_q.pm[crx_pkg::PM_LOOPBACK] |=> !tone_active)
		else $error("tone at 64k");
	// bit clock passed through as the sequencing clock
	seq_bclk_a: assert property (s_q.pm[crx_pkg::PM_BCLK_SEQ] |=> seq_clk == $past(s_q.bc_q))
		else $error("seq source");
	// a four-clock enable into an empty buffer gives a 32k word
	rate_len_a: assert property (fs_fall && !pcm_mode && !dig_pd && s_q.cnt == crx_pkg::LEN_32K && !s_q.b0_v
		|=> word_rate == 3'(crx_pkg::CRX_R32)) else $error("rate from length");
	byp_a: assert property (reg_wr && reg_addr == crx_pkg::REG_RX_ANALOG |=> filter_bypass == $past(reg_wdata[4]))
		else $error("bypass");
	word_c: cover property (push ##[1:400] word_valid && word_ready);
	full_c: cover property (s_q.b1_v);
	tone_c: cover property (s_q.tone);
	pcm_c: cover property (push && pcm_mode);
	quiet_c: cover property ($fell(tx_out_oe_n));
endmodule
`default_nettype wire

// File: testbench/crx_pcm_far.sv
// crx_pcm_far: behavioural pcm highway switch driving the receive pins
// assumes the bench calls its tasks from one process, paced by core_clk edges
`timescale 1ns/1ps
`default_nettype none
module crx_pcm_far (
	// pacing clock
	input  wire logic clk,
	// highway pins toward the block
	output logic      rx_data,
	output logic      rx_bclk,
	output logic      rx_fen,
	output logic      tx_fen
);
	int half = 4; // bit clock half period in core cycles, kept above three
	initial begin
		rx_data = 1'b0;
		rx_bclk = 1'b0;
		rx_fen  = 1'b0;
		tx_fen  = 1'b0;
	end
	// one receive word, msb first; bit clock stands still outside frames
	task automatic send(input int len, input logic [7:0] word);
		rx_fen <= 1'b1;
		for (int i = len - 1; i >= 0; i--) begin
			repeat (half) @(posedge clk);
			rx_bclk <= 1'b1;
			// launched on the rising edge so it stands still across the falling one
			rx_data <= word[i];
			repeat (half) @(posedge clk);
			rx_bclk <= 1'b0;
		end
		repeat (half) @(posedge clk);
		rx_fen  <= 1'b0;
		rx_data <= ~rx_data; // released line must not look like the last bit
		repeat (half) @(posedge clk);
	endtask
	// one transmit frame sync pulse
	task automatic tx_pulse;
		tx_fen <= 1'b1;
		repeat (2 * half) @(posedge clk);
		tx_fen <= 1'b0;
		repeat (2 * half) @(posedge clk);
	endtask
endmodule
`default_nettype wire

// File: testbench/crx_core_tb.sv
// crx_core_tb: self-checking bench for receive capture, registers and power control
// assumes crx_pcm_far drives the highway pins; the bench drives the rest
`timescale 1ns/1ps
`default_nettype none
module crx_core_tb;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        sdi, bclk, fen, tfen;
	logic        pdn = 1'b1, pi_pin = 1'b0, wr = 1'b0, rd = 1'b0;
	logic        lv = 1'b0, dv = 1'b0, tone = 1'b0, rdy = 1'b0;
	logic [3:0]  addr = 4'h0;
	logic [7:0]  wd = 8'h00, dw = 8'h00, rdat, wdat, d;
	logic [12:0] ls = 13'h0000, gs;
	logic [2:0]  wrate, trim, side;
	logic        wv, sadj, tact, den, csr, fbyp, mpd, apd, anapd, sclk, sbclk, toe_n, coe_n, sp;
	int          n_fail = 0, num_checks = 0, k, cnt;
	int          lens[5] = '{2, 3, 4, 8, 5};
	always #25 clk = ~clk;
	crx_pcm_far far (.clk(clk), .rx_data(sdi), .rx_bclk(bclk), .rx_fen(fen), .tx_fen(tfen));
	crx_core dut (.core_clk(clk), .rst_n(rst_n), .receive_serial_in(sdi), .receive_bit_clock(bclk),
		.receive_frame_enable(fen), .transmit_frame_enable(tfen), .powerdown_reset_pin(pdn),
		.main_driver_inverting_input(pi_pin), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wd),
		.reg_rdata(rdat), .linear_sample(ls), .linear_valid(lv), .decoded_word(dw), .decoded_valid(dv),
		.tone_request(tone), .word_valid(wv), .word_ready(rdy), .word_data(wdat), .word_rate(wrate),
		.sync_adjust_en(sadj), .gained_sample(gs), .tone_active(tact), .decoder_enable(den),
		.coder_state_reset(csr), .filter_bypass(fbyp), .rx_trim(trim), .sidetone_sel(side),
		.main_driver_pd(mpd), .aux_driver_pd(apd), .analog_pd(anapd), .seq_clk(sclk),
		.seq_from_bclk(sbclk), .tx_out_oe_n(toe_n), .ctrl_out_oe_n(coe_n));
	// compare and count
	task automatic chk(input logic [12:0] got, input logic [12:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic end_of_test;
		if (n_fail == 0 && num_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// control port write and read, read data taken two edges later
	task automatic wreg(input logic [3:0] a, input logic [7:0] v);
		addr <= a;
		wd <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rreg(input logic [3:0] a, input logic [7:0] e);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		repeat (2) @(posedge clk);
		chk(13'(rdat), 13'(e));
	endtask
	// expected rate for an enable length
	function automatic logic [2:0] rate_of(input int len);
		case (len)
			2: return crx_pkg::CRX_R16;
			3: return crx_pkg::CRX_R24;
			4: return crx_pkg::CRX_R32;
			8: return crx_pkg::CRX_R64;
			default: return crx_pkg::CRX_RBAD;
		endcase
	endfunction
	// wait for the buffer head, compare the low len bits and the rate, then pop
	task automatic pop(input int len, input logic [7:0] v);
		logic [7:0] m;
		m = 8'((9'h001 << len) - 9'h001);
		for (k = 0; k < 40 && wv !== 1'b1; k++) @(posedge clk);
		chk(13'(wv), 13'h0001);
		chk(13'(wdat & m), 13'(v & m));
		chk(13'(wrate), 13'(rate_of(len)));
		rdy <= 1'b1;
		@(posedge clk);
		rdy <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	initial begin
		#2000000;
		n_fail++;
		end_of_test();
	end
	initial begin
		void'($urandom(32'ha8f8a3c7));
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge clk);
		chk(13'({anapd, sadj}), 13'h0001);
		rreg(crx_pkg::REG_RX_GAIN, crx_pkg::RST_RX_GAIN);
		wreg(4'h9, 8'hff); // unmapped place leaves the others alone
		rreg(crx_pkg::REG_RX_ANALOG, crx_pkg::RST_RX_ANALOG);
		for (int i = 0; i < 8; i++) begin
			d = {1'b0, i[0], i[1], i[2], 1'b0, i[2:0]};
			wreg(crx_pkg::REG_RX_ANALOG, d);
			wreg(crx_pkg::REG_TX_GAIN_SIDE, {1'b0, i[2:0], 4'h0});
			@(posedge clk);
			chk(13'({apd, mpd, fbyp, trim}), 13'({i[0], i[1], i[2], i[2:0]}));
			chk(13'(side), 13'(i[2:0]));
			rreg(crx_pkg::REG_RX_ANALOG, d);
		end
		pi_pin <= 1'b1;
		repeat (8) @(posedge clk);
		chk(13'(mpd), 13'h0001);
		pi_pin <= 1'b0;
		// unity then half gain on a linear sample
		for (int g = 0; g < 2; g++) begin
			wreg(crx_pkg::REG_RX_GAIN, g ? 8'h40 : 8'h80);
			ls <= 13'h0123;
			lv <= 1'b1;
			@(posedge clk);
			lv <= 1'b0;
			repeat (3) @(posedge clk);
			chk(gs, g ? 13'h0091 : 13'h0123);
			chk(13'(sadj), 13'(g == 0));
		end
		dw <= 8'($urandom);
		dv <= 1'b1;
		@(posedge clk);
		dv <= 1'b0;
		rreg(crx_pkg::REG_DECODED, dw);
		// every rate frame after frame, then an invalid length
		for (int i = 0; i < 5; i++) begin
			d = 8'($urandom);
			far.send(lens[i], d);
			if (i < 4) pop(lens[i], d);
		end
		repeat (10) @(posedge clk);
		chk(13'(wv), 13'h0000);
		// receiver stalls: third word refused, two survive
		for (int i = 0; i < 3; i++) far.send(8, 8'hc3 ^ 8'(i));
		pop(8, 8'hc3);
		pop(8, 8'hc2);
		chk(13'(wv), 13'h0000);
		// last word was 64k: tone blocked until loopback
		tone <= 1'b1;
		repeat (3) @(posedge clk);
		chk(13'(tact), 13'h0000);
		wreg(crx_pkg::REG_POWER_MODE, 8'h20);
		@(posedge clk);
		chk(13'({tact, den}), 13'h0002);
		tone <= 1'b0;
		wreg(crx_pkg::REG_POWER_MODE, 8'h80);
		chk(13'(sbclk), 13'h0001);
		// codec mode: short enable still yields a full 64k word
		wreg(crx_pkg::REG_POWER_MODE, 8'h08);
		far.send(8, 8'h96);
		pop(8, 8'h96);
		far.send(3, 8'h05);
		pop(8, 8'hb5);
		wreg(crx_pkg::REG_POWER_MODE, 8'h02);
		far.send(4, 8'h05);
		repeat (10) @(posedge clk);
		chk(13'(wv), 13'h0000);
		wreg(crx_pkg::REG_POWER_MODE, 8'h00);
		cnt = 0;
		sp = sclk;
		repeat (780) begin
			@(posedge clk);
			if (sclk && !sp) cnt++;
			sp = sclk;
		end
		chk(13'(cnt >= 9 && cnt <= 11), 13'h0001);
		pdn <= 1'b0;
		repeat (8) @(posedge clk);
		chk(13'({anapd, toe_n, coe_n}), 13'h0007);
		pdn <= 1'b1;
		cnt = 0;
		repeat (12) begin
			@(posedge clk);
			if (csr === 1'b1) cnt++;
		end
		chk(13'(cnt), 13'h0001);
		far.tx_pulse();
		chk(13'(toe_n), 13'h0001);
		repeat (2) far.tx_pulse();
		chk(13'(toe_n), 13'h0000);
		end_of_test();
	end
endmodule
`default_nettype wire
